// ---- hdl/kwdt_core.sv ----
// keyed watchdog timer with unlock sequence, select-pin view and wake warning
// Contract
// - writing 32h 5Dh 42h ACh in order to the unlock port sets unlock-granted
// - writing 35h to the unlock port while unlocked clears unlock-granted
// - writes to protected registers take effect only while unlocked
// - select status reads the three select pins in bits 2:0, zeros above
// - clock-choice bit: 0 uses host clock, 1 the internal 500 kHz source
// - expiry sets the flag in bit 6; writing one clears it
// - counting runs only while enable bit 5 is one; reset from strap
// - bit 4 picks level or pulse behaviour of the expiry output
// - bit 3 picks a one second or sixty second tick
// - bit 2 picks active high or active low expiry output
// - pulse width field picks 1 ms, 25 ms, 125 ms or 5 s
// - eight-bit time count register, reset value 0Ah
// - wake register bit 7 shows the live wake event
// - with wake enable set, wake event rises one tick before expiry
// - a sticky bit records each wake event
// - socket flag set on debounced rising socket input, cleared by writing one
// - expiry output is driven only while the output enable bit is one
`timescale 1ns/100ps
`default_nettype none
module kwdt_core #(
  parameter int unsigned SEC_CYCLES = kwdt_pkg::SEC_CYC,
  parameter int unsigned OSC_PER_SEC = kwdt_pkg::OSC_PER_SEC,
  parameter int unsigned PW0_CYCLES = kwdt_pkg::PW0_CYC,
  parameter int unsigned PW1_CYCLES = kwdt_pkg::PW1_CYC,
  parameter int unsigned PW2_CYCLES = kwdt_pkg::PW2_CYC,
  parameter int unsigned PW3_CYCLES = kwdt_pkg::PW3_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // pins
  input wire logic [2:0] select_input_pins,
  input wire logic socket_occupied,
  input wire logic strap_trap_pin,
  input wire logic clock_choice_pin,
  // outputs
  output logic expiry_reset_output,
  output logic irq
);

  // pulse width selected by the two-bit field
  function automatic logic [31:0] pw_cycles(input logic [1:0] sel);
    logic [31:0] r;
    r = 32'(PW0_CYCLES);
    unique case (sel)
      2'h0: r = 32'(PW0_CYCLES);
      2'h1: r = 32'(PW1_CYCLES);
      2'h2: r = 32'(PW2_CYCLES);
      2'h3: r = 32'(PW3_CYCLES);
    endcase
    return r;
  endfunction

  // expected byte at each step of the unlock sequence
  function automatic logic [7:0] key_byte(input logic [1:0] idx);
    logic [7:0] r;
    r = kwdt_pkg::KEY_B0;
    unique case (idx)
      2'h0: r = kwdt_pkg::KEY_B0;
      2'h1: r = kwdt_pkg::KEY_B1;
      2'h2: r = kwdt_pkg::KEY_B2;
      2'h3: r = kwdt_pkg::KEY_B3;
    endcase
    return r;
  endfunction

  // pin synchronisers, three stages each; kept out of reset so the strap
  // capture on the third edge after release already sees the real pin levels
  logic [2:0] sel_s1, sel_s2, sel_s3;
  logic sock_s1, sock_s2, sock_s3;
  logic strap_s1, strap_s2, strap_s3;
  logic clks_s1, clks_s2, clks_s3;
  always_ff @(posedge clk) begin
    sel_s1 <= select_input_pins;
    sel_s2 <= sel_s1;
    sel_s3 <= sel_s2;
    sock_s1 <= socket_occupied;
    sock_s2 <= sock_s1;
    sock_s3 <= sock_s2;
    strap_s1 <= strap_trap_pin;
    strap_s2 <= strap_s1;
    strap_s3 <= strap_s2;
    clks_s1 <= clock_choice_pin;
    clks_s2 <= clks_s1;
    clks_s3 <= clks_s2;
  end

  // register state
  logic [7:0] key_val, expiry_count;
  logic [1:0] key_idx, pw_sel, strap_cnt;
  logic unlocked, out_en, clk_choice, count_enable, exp_flag, pulse_mode;
  logic unit_min, pol, wake_en, wake_flag, sock_flag, load;
  logic [2:0] irq_st, irq_mask;
  logic [7:0] next_key_val, next_expiry_count, next_rdata;
  logic [1:0] next_key_idx, next_pw_sel, next_strap_cnt;
  logic next_unlocked, next_out_en, next_clk_choice, next_count_enable, next_exp_flag;
  logic next_pulse_mode, next_unit_min, next_pol, next_wake_en, next_wake_flag;
  logic next_sock_flag, next_load;
  logic [2:0] next_irq_st, next_irq_mask;
  // events from the timer and socket logic
  logic expire_evt, wake_set, sock_rise, wake_live;
  logic wr_key, wr_prot, wr_cfg, wr_ctrl, wr_count, wr_wake, wr_ist, wr_imask;
  logic [7:0] rv;

  // register file: decode, unlock sequence, write-one-clear flags, read mux
  always_comb begin
    wr_key = reg_wr && reg_addr == kwdt_pkg::OFS_KEY;
    wr_prot = reg_wr && unlocked;
    wr_cfg = wr_prot && reg_addr == kwdt_pkg::OFS_CFG;
    wr_ctrl = wr_prot && reg_addr == kwdt_pkg::OFS_CTRL;
    wr_count = wr_prot && reg_addr == kwdt_pkg::OFS_COUNT;
    wr_wake = wr_prot && reg_addr == kwdt_pkg::OFS_WAKE;
    wr_ist = reg_wr && reg_addr == kwdt_pkg::OFS_IRQ_ST;
    wr_imask = reg_wr && reg_addr == kwdt_pkg::OFS_IRQ_MASK;
    next_key_val = wr_key ? reg_wdata : key_val;
    next_key_idx = key_idx;
    next_unlocked = unlocked;
    if (wr_key) begin
      if (unlocked && reg_wdata == kwdt_pkg::KEY_LOCK) begin
        next_unlocked = 1'b0;
        next_key_idx = 2'h0;
      end else if (reg_wdata == key_byte(key_idx)) begin
        next_key_idx = key_idx + 2'h1;
        if (key_idx == 2'h3) begin
          next_unlocked = 1'b1;
        end
      end else begin
        // a wrong byte restarts, but may itself open a new sequence
        next_key_idx = (reg_wdata == kwdt_pkg::KEY_B0) ? 2'h1 : 2'h0;
      end
    end
    // straps are caught once the synchronisers have filled after reset
    next_strap_cnt = (strap_cnt == kwdt_pkg::STRAP_DONE) ? strap_cnt : strap_cnt + 2'h1;
    next_out_en = out_en;
    next_count_enable = count_enable;
    next_clk_choice = clk_choice;
    if (strap_cnt == 2'h2) begin
      next_out_en = strap_s3;
      next_count_enable = strap_s3;
      next_clk_choice = clks_s3;
    end
    if (wr_cfg) begin
      next_out_en = reg_wdata[kwdt_pkg::CFG_OUTEN_BIT];
    end
    next_pulse_mode = pulse_mode;
    next_unit_min = unit_min;
    next_pol = pol;
    next_pw_sel = pw_sel;
    if (wr_ctrl) begin
      next_count_enable = reg_wdata[kwdt_pkg::CTRL_EN_BIT];
      next_pulse_mode = reg_wdata[kwdt_pkg::CTRL_PULSE_BIT];
      next_unit_min = reg_wdata[kwdt_pkg::CTRL_UNIT_BIT];
      next_pol = reg_wdata[kwdt_pkg::CTRL_POL_BIT];
      next_pw_sel = reg_wdata[kwdt_pkg::CTRL_PW_LSB +: 2];
    end
    next_expiry_count = wr_count ? reg_wdata : expiry_count;
    next_wake_en = wr_wake ? reg_wdata[kwdt_pkg::WAKE_EN_BIT] : wake_en;
    // sticky flags: a set in the same cycle as a clear wins
    next_exp_flag = expire_evt || (exp_flag && !(wr_ctrl && reg_wdata[kwdt_pkg::CTRL_EXP_BIT]));
    next_wake_flag = wake_set
      || (wake_flag && !(wr_wake && reg_wdata[kwdt_pkg::WAKE_ST_BIT]));
    next_sock_flag = sock_rise
      || (sock_flag && !(wr_wake && reg_wdata[kwdt_pkg::WAKE_SOCK_BIT]));
    next_irq_st = irq_st & ~(wr_ist ? reg_wdata[2:0] : 3'h0);
    next_irq_st[kwdt_pkg::IRQ_EXP_BIT] = next_irq_st[kwdt_pkg::IRQ_EXP_BIT] | expire_evt;
    next_irq_st[kwdt_pkg::IRQ_WAKE_BIT] = next_irq_st[kwdt_pkg::IRQ_WAKE_BIT] | wake_set;
    next_irq_st[kwdt_pkg::IRQ_SOCK_BIT] = next_irq_st[kwdt_pkg::IRQ_SOCK_BIT] | sock_rise;
    next_irq_mask = wr_imask ? reg_wdata[2:0] : irq_mask;
    // reload on enable rising or on a rewrite of the count
    next_load = wr_count || (next_count_enable && !count_enable);
    rv = 8'h00;
    unique case (reg_addr)
      kwdt_pkg::OFS_CFG: rv[kwdt_pkg::CFG_OUTEN_BIT] = out_en;
      kwdt_pkg::OFS_KEYST: rv[kwdt_pkg::KEYST_OK_BIT] = unlocked;
      kwdt_pkg::OFS_KEY: rv = key_val;
      kwdt_pkg::OFS_SEL: rv[2:0] = sel_s3;
      kwdt_pkg::OFS_CTRL: begin
        rv[kwdt_pkg::CTRL_CLK_BIT] = clk_choice;
        rv[kwdt_pkg::CTRL_EXP_BIT] = exp_flag;
        rv[kwdt_pkg::CTRL_EN_BIT] = count_enable;
        rv[kwdt_pkg::CTRL_PULSE_BIT] = pulse_mode;
        rv[kwdt_pkg::CTRL_UNIT_BIT] = unit_min;
        rv[kwdt_pkg::CTRL_POL_BIT] = pol;
        rv[kwdt_pkg::CTRL_PW_LSB +: 2] = pw_sel;
      end
      kwdt_pkg::OFS_COUNT: rv = expiry_count;
      kwdt_pkg::OFS_WAKE: begin
        rv[kwdt_pkg::WAKE_LIVE_BIT] = wake_live;
        rv[kwdt_pkg::WAKE_EN_BIT] = wake_en;
        rv[kwdt_pkg::WAKE_ST_BIT] = wake_flag;
        rv[kwdt_pkg::WAKE_SOCK_BIT] = sock_flag;
      end
      kwdt_pkg::OFS_IRQ_ST: rv[2:0] = irq_st;
      kwdt_pkg::OFS_IRQ_MASK: rv[2:0] = irq_mask;
      default: rv = 8'h00; // unmapped addresses read zero
    endcase
    next_rdata = reg_rd ? rv : 8'h00;
  end

  // register file flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      key_val <= kwdt_pkg::KEY_RST;
      key_idx <= 2'h0;
      unlocked <= 1'b0;
      strap_cnt <= 2'h0;
      out_en <= 1'b0;
      count_enable <= 1'b0;
      clk_choice <= 1'b0;
      pulse_mode <= 1'b0;
      unit_min <= 1'b0;
      pol <= 1'b0;
      pw_sel <= 2'h0;
      expiry_count <= kwdt_pkg::COUNT_RST;
      wake_en <= 1'b0;
      exp_flag <= 1'b0;
      wake_flag <= 1'b0;
      sock_flag <= 1'b0;
      irq_st <= 3'h0;
      irq_mask <= 3'h0;
      load <= 1'b0;
      reg_rdata <= 8'h00;
    end else begin
      key_val <= next_key_val;
      key_idx <= next_key_idx;
      unlocked <= next_unlocked;
      strap_cnt <= next_strap_cnt;
      out_en <= next_out_en;
      count_enable <= next_count_enable;
      clk_choice <= next_clk_choice;
      pulse_mode <= next_pulse_mode;
      unit_min <= next_unit_min;
      pol <= next_pol;
      pw_sel <= next_pw_sel;
      expiry_count <= next_expiry_count;
      wake_en <= next_wake_en;
      exp_flag <= next_exp_flag;
      wake_flag <= next_wake_flag;
      sock_flag <= next_sock_flag;
      irq_st <= next_irq_st;
      irq_mask <= next_irq_mask;
      load <= next_load;
      reg_rdata <= next_rdata;
    end
  end

  // timer: tick prescalers and countdown
  kwdt_pkg::kwdt_state_t state, next_state;
  logic [7:0] osc_div, next_osc_div, wd_cnt, next_wd_cnt;
  logic [31:0] sec_cnt, next_sec_cnt, sec_lim;
  logic [5:0] min_cnt, next_min_cnt;
  logic next_expire_evt, next_wake_live, next_wake_set, base_ev, sec_tick, unit_tick;
  always_comb begin
    // the 500 kHz source is modelled as a divided enable of clk
    next_osc_div = (osc_div == kwdt_pkg::OSC_DIV_CYC - 8'h01) ? 8'h00 : osc_div + 8'h01;
    base_ev = !clk_choice || osc_div == kwdt_pkg::OSC_DIV_CYC - 8'h01;
    sec_lim = clk_choice ? 32'(OSC_PER_SEC) : 32'(SEC_CYCLES);
    sec_tick = base_ev && sec_cnt == sec_lim - 32'h1;
    unit_tick = sec_tick && (!unit_min || min_cnt == kwdt_pkg::MIN_SECS - 6'h01);
    next_sec_cnt = sec_cnt;
    next_min_cnt = min_cnt;
    if (base_ev) begin
      next_sec_cnt = sec_tick ? 32'h0 : sec_cnt + 32'h1;
    end
    if (sec_tick) begin
      next_min_cnt = unit_tick ? 6'h00 : min_cnt + 6'h01;
    end
    next_state = state;
    next_wd_cnt = wd_cnt;
    next_expire_evt = 1'b0;
    unique case (state)
      kwdt_pkg::WD_IDLE, kwdt_pkg::WD_DONE: begin
        if (load && count_enable) begin
          next_state = kwdt_pkg::WD_RUN;
        end
      end
      kwdt_pkg::WD_RUN: begin
        if (!count_enable) begin
          next_state = kwdt_pkg::WD_IDLE;
        end else if (unit_tick && !load) begin
          if (wd_cnt <= 8'h01) begin
            next_wd_cnt = 8'h00;
            next_expire_evt = 1'b1;
            next_state = kwdt_pkg::WD_DONE;
          end else begin
            next_wd_cnt = wd_cnt - 8'h01;
          end
        end
      end
      default: next_state = kwdt_pkg::WD_IDLE; // recover from a corrupted code
    endcase
    // a reload restarts the count and the prescalers together
    if (load) begin
      next_wd_cnt = expiry_count;
      next_sec_cnt = 32'h0;
      next_min_cnt = 6'h00;
      next_osc_div = 8'h00;
    end
    next_wake_live = wake_en && next_state == kwdt_pkg::WD_RUN && next_wd_cnt == 8'h01;
    next_wake_set = next_wake_live && !wake_live;
  end

  // timer flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= kwdt_pkg::WD_IDLE;
      osc_div <= 8'h00;
      sec_cnt <= 32'h0;
      min_cnt <= 6'h00;
      wd_cnt <= 8'h00;
      expire_evt <= 1'b0;
      wake_live <= 1'b0;
      wake_set <= 1'b0;
    end else begin
      state <= next_state;
      osc_div <= next_osc_div;
      sec_cnt <= next_sec_cnt;
      min_cnt <= next_min_cnt;
      wd_cnt <= next_wd_cnt;
      expire_evt <= next_expire_evt;
      wake_live <= next_wake_live;
      wake_set <= next_wake_set;
    end
  end

  // expiry output, socket debounce and interrupt
  logic act, next_act, sock_stable, next_sock_stable, next_sock_rise;
  logic next_out, next_irq;
  logic [31:0] pulse_cnt, next_pulse_cnt;
  logic [6:0] deb_cnt, next_deb_cnt;
  always_comb begin
    next_pulse_cnt = 32'h0;
    if (pulse_mode) begin
      next_act = act;
      if (act) begin
        // one pulse per expiry; a second expiry in the pulse is absorbed
        if (pulse_cnt >= pw_cycles(pw_sel) - 32'h1) begin
          next_act = 1'b0;
        end else begin
          next_pulse_cnt = pulse_cnt + 32'h1;
        end
      end else if (expire_evt && out_en) begin
        next_act = 1'b1;
      end
    end else begin
      next_act = out_en && exp_flag;
    end
    if (!out_en) begin
      next_act = 1'b0;
    end
    next_out = pol ? next_act : !next_act;
    next_irq = |(next_irq_st & next_irq_mask);
    // debounce: level must stay put for the whole window before it counts
    next_deb_cnt = 7'h00;
    next_sock_stable = sock_stable;
    next_sock_rise = 1'b0;
    if (sock_s2 == sock_s3 && sock_s3 != sock_stable) begin
      if (deb_cnt == kwdt_pkg::DEB_CYC - 7'h01) begin
        next_sock_stable = sock_s3;
        next_sock_rise = sock_s3;
      end else begin
        next_deb_cnt = deb_cnt + 7'h01;
      end
    end
  end

  // output and socket flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      act <= 1'b0;
      pulse_cnt <= 32'h0;
      expiry_reset_output <= 1'b1;
      irq <= 1'b0;
      deb_cnt <= 7'h00;
      sock_stable <= 1'b0;
      sock_rise <= 1'b0;
    end else begin
      act <= next_act;
      pulse_cnt <= next_pulse_cnt;
      expiry_reset_output <= next_out;
      irq <= next_irq;
      deb_cnt <= next_deb_cnt;
      sock_stable <= next_sock_stable;
      sock_rise <= next_sock_rise;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_key_unlock: assert property (wr_key && reg_wdata == kwdt_pkg::KEY_B3 && key_idx == 2'h3
    |=> unlocked) else $error("unlock sequence not granted");
  a_key_relock: assert property (wr_key && unlocked && reg_wdata == kwdt_pkg::KEY_LOCK
    |=> !unlocked) else $error("lock byte did not clear grant");
  a_locked_ignore: assert property (reg_wr && reg_addr == kwdt_pkg::OFS_COUNT && !unlocked
    |=> expiry_count == $past(expiry_count)) else $error("locked write took effect");
  a_select_read: assert property (reg_rd && reg_addr == kwdt_pkg::OFS_SEL
    |=> reg_rdata == {5'h00, $past(sel_s3)}) else $error("select status wrong");
  a_expiry_flag: assert property (expire_evt |=> exp_flag && state == kwdt_pkg::WD_DONE)
    else $error("expiry flag not set");
  a_count_hold: assert property (!count_enable && !load |=> $stable(wd_cnt))
    else $error("count moved while disabled");
  a_level_mode: assert property (!pulse_mode && out_en && exp_flag |=> act)
    else $error("level output not held");
  a_out_polarity: assert property (1'b1 |=> expiry_reset_output == ($past(pol) ? act : !act))
    else $error("output polarity wrong");
  a_pulse_bound: assert property (act && pulse_mode |-> pulse_cnt < pw_cycles(pw_sel))
    else $error("pulse too long");
  a_wake_early: assert property (wake_live |-> wd_cnt == 8'h01 && state == kwdt_pkg::WD_RUN)
    else $error("wake not one tick early");
  a_wake_sticky: assert property (wake_set |=> wake_flag) else $error("wake not recorded");
  a_sock_flag: assert property (sock_rise |=> sock_flag) else $error("socket flag missed");
  a_out_gate: assert property (!out_en |=> !act) else $error("output without enable");
  a_expire_zero: assert property (expire_evt |-> wd_cnt == 8'h00) else $error("early expiry");

  c_unlock: cover property (wr_key && reg_wdata == kwdt_pkg::KEY_B3 && key_idx == 2'h3);
  c_expire_pulse: cover property (expire_evt && pulse_mode && out_en ##1 act);
  c_wake: cover property (wake_set);
  c_sock: cover property (sock_rise ##1 sock_flag);

endmodule // kwdt_core
`default_nettype wire

// ---- hdl/kwdt_pkg.sv ----
// constants, register map and types for the keyed watchdog timer
package kwdt_pkg;
  // register offsets on the byte register port
  localparam logic [7:0] OFS_CFG = 8'hf0;
  localparam logic [7:0] OFS_KEYST = 8'hf2;
  localparam logic [7:0] OFS_KEY = 8'hf3;
  localparam logic [7:0] OFS_SEL = 8'hf4;
  localparam logic [7:0] OFS_CTRL = 8'hf5;
  localparam logic [7:0] OFS_COUNT = 8'hf6;
  localparam logic [7:0] OFS_WAKE = 8'hf7;
  localparam logic [7:0] OFS_IRQ_ST = 8'he0;
  localparam logic [7:0] OFS_IRQ_MASK = 8'he1;
  // unlock sequence and lock byte
  localparam logic [7:0] KEY_B0 = 8'h32;
  localparam logic [7:0] KEY_B1 = 8'h5d;
  localparam logic [7:0] KEY_B2 = 8'h42;
  localparam logic [7:0] KEY_B3 = 8'hac;
  localparam logic [7:0] KEY_LOCK = 8'h35;
  // field positions
  localparam int CFG_OUTEN_BIT = 7;
  localparam int KEYST_OK_BIT = 6;
  localparam int CTRL_CLK_BIT = 7;
  localparam int CTRL_EXP_BIT = 6;
  localparam int CTRL_EN_BIT = 5;
  localparam int CTRL_PULSE_BIT = 4;
  localparam int CTRL_UNIT_BIT = 3;
  localparam int CTRL_POL_BIT = 2;
  localparam int CTRL_PW_LSB = 0;
  localparam int WAKE_LIVE_BIT = 7;
  localparam int WAKE_EN_BIT = 6;
  localparam int WAKE_ST_BIT = 5;
  localparam int WAKE_SOCK_BIT = 0;
  localparam int IRQ_EXP_BIT = 0;
  localparam int IRQ_WAKE_BIT = 1;
  localparam int IRQ_SOCK_BIT = 2;
  // values after reset
  localparam logic [7:0] KEY_RST = 8'hf3;
  localparam logic [7:0] COUNT_RST = 8'h0a;
  localparam logic [1:0] STRAP_DONE = 2'h3;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SEC_NS = 1000000000;
  localparam int MS_NS = 1000000;
  localparam int SEC_CYC = SEC_NS / CLK_PERIOD_NS;
  localparam int MS_CYC = MS_NS / CLK_PERIOD_NS;
  localparam int OSC_PERIOD_NS = 2000;
  localparam logic [7:0] OSC_DIV_CYC = 8'(OSC_PERIOD_NS / CLK_PERIOD_NS);
  localparam int OSC_PER_SEC = SEC_NS / OSC_PERIOD_NS;
  localparam logic [5:0] MIN_SECS = 6'd60;
  localparam int PW0_MS = 1;
  localparam int PW1_MS = 25;
  localparam int PW2_MS = 125;
  localparam int PW3_S = 5;
  localparam int PW0_CYC = PW0_MS * MS_CYC;
  localparam int PW1_CYC = PW1_MS * MS_CYC;
  localparam int PW2_CYC = PW2_MS * MS_CYC;
  localparam int PW3_CYC = PW3_S * SEC_CYC;
  localparam int DEB_NS = 1000;
  localparam logic [6:0] DEB_CYC = 7'((DEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // watchdog sequencer states
  typedef enum logic [2:0] {
    WD_IDLE = 3'b001,
    WD_RUN = 3'b010,
    WD_DONE = 3'b100
  } kwdt_state_t;
endpackage

// ---- verif/kwdt_board_model.sv ----
// board-side model: select pins, socket input and power-on strap
`timescale 1ns/100ps
`default_nettype none
module kwdt_board_model (
  // clock
  input wire logic clk,
  // requests from the bench
  input wire logic [2:0] sel_req,
  input wire logic sock_req,
  input wire logic strap_req,
  // pins toward the device
  // pins start at a defined level so the synchronisers never see unknowns
  output logic [2:0] select_input_pins = 3'h0,
  output logic socket_occupied = 1'b0,
  output logic strap_trap_pin = 1'b0
);
  // pins follow the requests a cycle late, unrelated to any register access
  always @(posedge clk) begin
    select_input_pins <= sel_req;
    socket_occupied <= sock_req;
    strap_trap_pin <= strap_req;
  end
endmodule // kwdt_board_model
`default_nettype wire

// ---- verif/keyed_watchdog_timer_test.sv ----
// self-checking bench for the keyed watchdog core
`timescale 1ns/100ps
`default_nettype none
module keyed_watchdog_timer_test;
  // shortened second and pulse counts keep the run brief
  localparam int SEC = 20;
  localparam int PW [4] = '{3, 4, 5, 6};
  // rows: address, mask, expected read value after reset
  localparam logic [23:0] ROWS [9] = '{24'hf3fff3, 24'hf6ff0a, 24'hf5ff00, 24'hf7ff00,
    24'hf4ff00, 24'hf08000, 24'he1ff00, 24'hf24000, 24'h10ff00};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [2:0] sel_req = 3'h0;
  logic sock_req = 1'b0;
  logic strap_req = 1'b0;
  logic clock_choice_pin = 1'b0;
  logic [2:0] select_input_pins;
  logic socket_occupied;
  logic strap_trap_pin;
  logic expiry_reset_output;
  logic irq;
  logic [7:0] d;
  int n;
  int fail_count = 0;
  int compares = 0;

  always #5 clk = ~clk;

  kwdt_board_model u_board (.clk(clk), .sel_req(sel_req), .sock_req(sock_req),
    .strap_req(strap_req), .select_input_pins(select_input_pins),
    .socket_occupied(socket_occupied), .strap_trap_pin(strap_trap_pin));

  kwdt_core #(.SEC_CYCLES(SEC), .OSC_PER_SEC(2), .PW0_CYCLES(PW[0]), .PW1_CYCLES(PW[1]),
    .PW2_CYCLES(PW[2]), .PW3_CYCLES(PW[3])) u_dut (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .select_input_pins(select_input_pins),
    .socket_occupied(socket_occupied), .strap_trap_pin(strap_trap_pin),
    .clock_choice_pin(clock_choice_pin), .expiry_reset_output(expiry_reset_output),
    .irq(irq));

  // the verdict is printed in this one place only
  task automatic print_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one write cycle, strobe dropped at the next edge
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe, so sample it there
  task automatic chk8(input string name, input logic [7:0] a, input logic [7:0] m,
                      input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata & m;
    compares++;
    if (d !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", name, e, d);
    end
  endtask
  // compare a cycle count or a flag against a window
  task automatic chk_rng(input string name, input int lo, input int hi, input int got);
    compares++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("FAIL %s expected %0d..%0d seen %0d", name, lo, hi, got);
    end
  endtask
  // bounded wait for the output level, counting cycles
  task automatic wait_out(input logic lvl, input int max, output int c);
    c = 0;
    while (expiry_reset_output !== lvl) begin
      @(negedge clk);
      c++;
      if (c > max) begin
        fail_count++;
        $display("FAIL expiry_reset_output expected %b seen %b", lvl, expiry_reset_output);
        print_verdict();
      end
    end
  endtask
  task automatic unlock();
    wr(8'hf3, 8'h32);
    wr(8'hf3, 8'h5d);
    wr(8'hf3, 8'h42);
    wr(8'hf3, 8'hac);
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    // reset values, locked state and an unmapped address
    for (int i = 0; i < 9; i++) begin
      chk8("reset_row", ROWS[i][23:16], ROWS[i][15:8], ROWS[i][7:0]);
    end
    wr(8'hf6, 8'h05);
    chk8("count_locked", 8'hf6, 8'hff, 8'h0a);
    // a wrong byte in mid-sequence must restart the unlock
    wr(8'hf3, 8'h32);
    wr(8'hf3, 8'h5d);
    wr(8'hf3, 8'h00);
    wr(8'hf3, 8'h42);
    wr(8'hf3, 8'hac);
    chk8("unlock_bad", 8'hf2, 8'h40, 8'h00);
    unlock();
    chk8("unlock_ok", 8'hf2, 8'h40, 8'h40);
    @(posedge clk);
    sel_req <= 3'h5;
    repeat (6) @(posedge clk);
    chk8("select_pins", 8'hf4, 8'hff, 8'h05);
    // level mode, active low, wake enabled, interrupt masked at first
    wr(8'he1, 8'h00);
    wr(8'hf0, 8'h80);
    wr(8'hf6, 8'h03);
    wr(8'hf7, 8'h40);
    wr(8'hf5, 8'h20);
    wait_out(1'b0, 5 * SEC, n);
    chk_rng("expiry_time", 2 * SEC, 3 * SEC + 6, n);
    chk8("expiry_flag", 8'hf5, 8'h40, 8'h40);
    chk8("wake_flags", 8'hf7, 8'ha0, 8'h20);
    chk_rng("irq_masked", 0, 0, int'(irq !== 1'b0));
    wr(8'he1, 8'h03);
    repeat (3) @(negedge clk);
    chk_rng("irq_raised", 1, 1, int'(irq === 1'b1));
    wr(8'he0, 8'h07);
    repeat (3) @(negedge clk);
    chk_rng("irq_cleared", 0, 0, int'(irq !== 1'b0));
    chk_rng("level_hold", 1, 1, int'(expiry_reset_output === 1'b0));
    wr(8'hf5, 8'h40);
    wait_out(1'b1, 4, n);
    chk8("expiry_clear", 8'hf5, 8'h40, 8'h00);
    // pulse mode, active high, every width code
    wr(8'hf6, 8'h01);
    for (int p = 0; p < 4; p++) begin
      wr(8'hf5, 8'h34 | 8'(p));
      repeat (3) @(negedge clk);
      wait_out(1'b1, 4 * SEC, n);
      wait_out(1'b0, 10, n);
      chk_rng("pulse_width", PW[p], PW[p], n);
      wr(8'hf5, 8'h40);
    end
    // sixty second unit
    wr(8'hf5, 8'h28);
    wait_out(1'b0, 62 * SEC, n);
    chk_rng("unit_60", 59 * SEC, 60 * SEC + 6, n);
    wr(8'hf5, 8'h40);
    // lock again; protected writes are dropped once more
    wr(8'hf3, 8'h35);
    chk8("locked", 8'hf2, 8'h40, 8'h00);
    wr(8'hf6, 8'h07);
    chk8("count_kept", 8'hf6, 8'hff, 8'h01);
    // socket rise needs the debounce time before the flag shows
    @(posedge clk);
    sock_req <= 1'b1;
    repeat (60) @(negedge clk);
    chk8("socket_early", 8'hf7, 8'h01, 8'h00);
    repeat (80) @(negedge clk);
    chk8("socket_flag", 8'hf7, 8'h01, 8'h01);
    chk8("socket_irq", 8'he0, 8'h04, 8'h04);
    // sticky wake and socket flags clear on a written one
    unlock();
    wr(8'hf7, 8'h21);
    chk8("flags_clear", 8'hf7, 8'h21, 8'h00);
    // second reset with strap and internal clock source chosen
    @(posedge clk);
    rst_n <= 1'b0;
    strap_req <= 1'b1;
    clock_choice_pin <= 1'b1;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk8("strap_ctrl", 8'hf5, 8'ha0, 8'ha0);
    chk8("strap_outen", 8'hf0, 8'h80, 8'h80);
    wait_out(1'b0, 4500, n);
    chk_rng("osc_expiry", 3600, 4500, n);
    print_verdict();
  end
endmodule // keyed_watchdog_timer_test
`default_nettype wire
